// >>> rtl/pdt_consts.svh
`ifndef PDT_CONSTS_SVH
`define PDT_CONSTS_SVH

`define PDT_ADDR_COUNT   16'h0002
`define PDT_ADDR_PERIOD  16'h0003
`define PDT_RESET_COUNT  16'h0fff
`define PDT_RESET_PERIOD 16'h0fff
`define PDT_CNT_W        16

`endif

// >>> rtl/pdt_pkg.sv
package pdt_pkg;

	typedef struct packed {
		logic        rdEn;
		logic        wrEn;
		logic [15:0] addr;
		logic [15:0] wrData;
	} pdt_bus_req_t;

	typedef struct packed {
		logic        hit;
		logic [15:0] rdData;
	} pdt_bus_rsp_t;

endpackage

// >>> rtl/pdt_down_counter.sv
`timescale 1ns/10ps
`include "pdt_consts.svh"

// Reloadable down counter stage; load has priority over count and reload.
module pdt_down_counter
	import pdt_pkg::*;
#(
	parameter int                W         = 16,
	parameter logic [W-1:0]      RESET_VAL = W'(`PDT_RESET_COUNT)
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	input  wire logic [W-1:0] reloadVal,
	output logic      [W-1:0] count,
	output logic              atZero
);

	typedef struct packed {
		logic [W-1:0] count;
	} pdt_cnt_state_t;

	pdt_cnt_state_t state_r;
	pdt_cnt_state_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (load) begin
			state_nxt.count = loadVal;
		end else if (state_r.count == '0) begin
			state_nxt.count = reloadVal;
		end else begin
			state_nxt.count = state_r.count - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r.count <= RESET_VAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign count  = state_r.count;
	assign atZero = (state_r.count == '0);

endmodule // pdt_down_counter

// >>> rtl/pdt_timer.sv
// Contract
// - Sixteen-bit count decrements by one every phase clock, no enable.
// - Reset loads the count register with 0x0fff.
// - Reset loads the period register with 0x0fff.
// - Count holds during reset; decrementing starts after reset release.
// - Count register at data address 2, period register at address 3.
// - Expiry request raised each time the count reaches zero with no count write in that zero cycle.
// - Cycle after zero reloads from period; interval is period plus one.
// - Both registers read and write any cycle; count read is live.
// - Period write alone leaves running count alone; used at next reload.
// - Loading count continues from new value without an interrupt.
`timescale 1ns/10ps
`include "pdt_consts.svh"

module pdt_timer
	import pdt_pkg::*;
#(
	parameter int W = `PDT_CNT_W
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  pdt_bus_req_t      busReq,
	output pdt_bus_rsp_t      busRsp,
	output logic              timer_expiry_irq
);

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [W-1:0] period;
		logic [15:0]  rdData;
		logic         hit;
		logic         irq;
	} pdt_state_t;

	pdt_state_t   state_r;
	pdt_state_t   state_nxt;
	logic         cntLoad;
	logic [W-1:0] count;
	logic         atZero;
	logic         selCount;
	logic         selPeriod;

	assign selCount  = (busReq.addr == `PDT_ADDR_COUNT);
	assign selPeriod = (busReq.addr == `PDT_ADDR_PERIOD);

	// A count write overrides the decrement and the reload in the same cycle, so the
	// zero that the old count would have reached never happens and no request fires.
	assign cntLoad = busReq.wrEn && selCount;

	////////////////////////////////////////////////////////////////////////////
	// Counter.

	// The reload takes the period register as it stands at the zero cycle, so a
	// period write alone only shapes the next interval.
	pdt_down_counter #(
		.W         (W),
		.RESET_VAL (W'(`PDT_RESET_COUNT))
	) u_counter (
		.clk       (clk),
		.resetn    (resetn),
		.load      (cntLoad),
		.loadVal   (busReq.wrData[W-1:0]),
		.reloadVal (state_r.period),
		.count     (count),
		.atZero    (atZero)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registers and bus.

	always_comb begin
		state_nxt        = state_r;
		state_nxt.hit    = busReq.rdEn && (selCount || selPeriod);
		state_nxt.rdData = '0;
		if (busReq.rdEn && selCount) begin
			state_nxt.rdData = 16'(count);
		end else if (busReq.rdEn && selPeriod) begin
			state_nxt.rdData = 16'(state_r.period);
		end
		if (busReq.wrEn && selPeriod) begin
			state_nxt.period = busReq.wrData[W-1:0];
		end
		// Pulse in the cycle after the zero count, one per expiry.
		state_nxt.irq = atZero && !cntLoad;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r.period <= W'(`PDT_RESET_PERIOD);
			state_r.rdData <= 16'h0000;
			state_r.hit    <= 1'b0;
			state_r.irq    <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign busRsp.hit       = state_r.hit;
	assign busRsp.rdData    = state_r.rdData;
	assign timer_expiry_irq = state_r.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	count_decrement_a: assert property (@(posedge clk) disable iff (!resetn)
		(count != '0) && !cntLoad |=> (count == $past(count) - W'(1)))
		else $error("Count did not decrement by one.");

	reset_count_a: assert property (@(posedge clk)
		!resetn |=> (count == W'(`PDT_RESET_COUNT)))
		else $error("Count not at reset value after reset.");

	reset_period_a: assert property (@(posedge clk)
		!resetn |=> (state_r.period == W'(`PDT_RESET_PERIOD)))
		else $error("Period not at reset value after reset.");

	// Judged one edge late, so that the unknown count before the first reset edge
	// never takes part in the comparison.
	hold_in_reset_a: assert property (@(posedge clk)
		!resetn ##1 !resetn |=> $stable(count))
		else $error("Count moved during reset.");

	reload_period_a: assert property (@(posedge clk) disable iff (!resetn)
		atZero && !cntLoad |=> (count == $past(state_r.period)))
		else $error("Count did not reload from period.");

	irq_on_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		atZero && !cntLoad |=> timer_expiry_irq)
		else $error("No expiry request after zero count.");

	irq_single_a: assert property (@(posedge clk) disable iff (!resetn)
		timer_expiry_irq && (state_r.period != '0) |=> !timer_expiry_irq)
		else $error("Expiry request longer than one cycle.");

	count_load_a: assert property (@(posedge clk) disable iff (!resetn)
		cntLoad |=> (count == $past(busReq.wrData[W-1:0])) && !timer_expiry_irq)
		else $error("Count write not taken or raised a request.");

	count_read_a: assert property (@(posedge clk) disable iff (!resetn)
		busReq.rdEn && selCount |=> busRsp.hit && (busRsp.rdData == 16'($past(count))))
		else $error("Count read did not return the live count.");

	period_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		busReq.wrEn && selPeriod && !selCount && (count != '0) |=>
		(count == $past(count) - W'(1)))
		else $error("Period write disturbed the running count.");

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	// The count must still hold its reset value at the first edge after release,
	// otherwise the first interval would come out one cycle short.
	release_hold_a: assert property (@(posedge clk)
		$rose(resetn) |->
		(count == W'(`PDT_RESET_COUNT)))
		else $error("Count moved before reset release.");

	release_step_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) && !cntLoad |=>
		(count == W'(`PDT_RESET_COUNT) - W'(1)))
		else $error("Count did not start after reset release.");

	////////////////////////////////////////////////////////////////////////////
	// Bus answers.

	period_read_a: assert property (@(posedge clk) disable iff (!resetn)
		busReq.rdEn && selPeriod |=>
		busRsp.hit && (busRsp.rdData == 16'($past(state_r.period))))
		else $error("Period read did not return the period.");

	period_write_a: assert property (@(posedge clk) disable iff (!resetn)
		busReq.wrEn && selPeriod |=>
		(state_r.period == $past(busReq.wrData[W-1:0])))
		else $error("Period write not taken.");

	// Other addresses belong to other data memory, so the timer must stay silent.
	other_addr_a: assert property (@(posedge clk) disable iff (!resetn)
		busReq.rdEn && !selCount && !selPeriod |=>
		!busRsp.hit && (busRsp.rdData == 16'h0000))
		else $error("Timer answered a read of another address.");

	idle_bus_a: assert property (@(posedge clk) disable iff (!resetn)
		!busReq.rdEn |=>
		!busRsp.hit && (busRsp.rdData == 16'h0000))
		else $error("Read answer without a read.");

	////////////////////////////////////////////////////////////////////////////
	// Expiry request.

	// Every pulse must trace back to a zero count that no count write cancelled.
	irq_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		timer_expiry_irq |->
		$past(atZero) && !$past(cntLoad))
		else $error("Expiry request without an expiry.");

	// The pulse stands in the reload cycle, so the count already shows the period.
	irq_align_a: assert property (@(posedge clk) disable iff (!resetn)
		timer_expiry_irq |->
		(count == $past(state_r.period)))
		else $error("Expiry request not aligned with the reload.");

	////////////////////////////////////////////////////////////////////////////
	// Coverage.

	expiry_seen_c: cover property (@(posedge clk) disable iff (!resetn)
		timer_expiry_irq);
	count_write_c: cover property (@(posedge clk) disable iff (!resetn)
		cntLoad);
	period_write_c: cover property (@(posedge clk) disable iff (!resetn)
		busReq.wrEn && selPeriod ##[1:20] timer_expiry_irq);
	reset_release_c: cover property (@(posedge clk)
		$rose(resetn));
	count_read_c: cover property (@(posedge clk) disable iff (!resetn)
		busReq.rdEn && selCount ##1 busRsp.hit);

endmodule // pdt_timer

// >>> verification/pdt_core_model.sv
`timescale 1ns/10ps
module pdt_core_model
	import pdt_pkg::*;
(
	input  wire logic   clk,
	output pdt_bus_req_t busReq,
	input  wire logic   timer_expiry_irq
);
	int irqCount = 0;
	// Software keeps the expiry request masked until both registers are programmed.
	logic irqEnable = 1'b0;
	initial busReq = '0;
	// Counted at the falling edge, where the pulse stands settled.
	always @(negedge clk) begin
		if (irqEnable && timer_expiry_irq === 1'b1) irqCount++;
	end
	// One-cycle strobe; released lines show the inverse so stale data cannot match.
	task automatic access(input logic rd, input logic wr, input logic [15:0] a,
		input logic [15:0] d);
		if (wr && a == 16'h0003 && d == 16'h0000) d = 16'h0001;
		busReq = '{rdEn: rd, wrEn: wr, addr: a, wrData: d};
		@(negedge clk);
		busReq = '{rdEn: 1'b0, wrEn: 1'b0, addr: ~a, wrData: ~d};
	endtask
endmodule // pdt_core_model

// >>> verification/periodic_down_timer_tb_top.sv
`timescale 1ns/10ps
module periodic_down_timer_tb_top
	import pdt_pkg::*;
;
	logic         clk = 0;
	logic         resetn = 0;
	pdt_bus_req_t busReq;
	pdt_bus_rsp_t busRsp;
	logic         irq;
	int           fail_count = 0;
	int           total_checks = 0;
	int           mIrqs = 0;
	int           cnt;
	int           timer_reload_period;
	logic         eHit;
	logic         eIrq;
	logic [15:0]  eRd;
	always #10 clk = ~clk;
	pdt_timer dut (.clk(clk), .resetn(resetn), .busReq(busReq), .busRsp(busRsp),
		.timer_expiry_irq(irq));
	pdt_core_model core (.clk(clk), .busReq(busReq), .timer_expiry_irq(irq));
	task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reference model; a count write beats reload, reload uses the old period.
	always @(posedge clk) begin
		if (!resetn) begin
			cnt = 'h0fff;
			timer_reload_period = 'h0fff;
			eHit = 0;
			eRd = 0;
			eIrq = 0;
		end else begin
			eHit = busReq.rdEn && busReq.addr inside {16'h0002, 16'h0003};
			eRd = !eHit ? 16'h0000 : busReq.addr == 16'h0002 ? cnt[15:0] : timer_reload_period[15:0];
			eIrq = 0;
			if (busReq.wrEn && busReq.addr == 16'h0002) cnt = busReq.wrData;
			else if (cnt == 0) begin
				cnt = timer_reload_period;
				eIrq = 1;
				if (core.irqEnable) mIrqs++;
			end else cnt--;
			if (busReq.wrEn && busReq.addr == 16'h0003) timer_reload_period = busReq.wrData;
		end
	end
	always @(negedge clk) begin
		check("irq", {15'h0, irq}, {15'h0, eIrq});
		check("hit", {15'h0, busRsp.hit}, {15'h0, eHit});
		check("rdData", busRsp.rdData, eRd);
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		int op;
		logic [15:0] a;
		logic [15:0] d;
		void'($urandom(88981));
		repeat (5) @(negedge clk);
		resetn = 1;
		// Long first run lets the reset count expire once untouched and reload from the reset period.
		repeat (4200) @(negedge clk);
		// The unused timer stays masked while its period serves as plain storage.
		core.access(1'b0, 1'b1, 16'h0003, 16'h5a5a);
		@(negedge clk);
		core.access(1'b1, 1'b0, 16'h0003, 16'h0000);
		@(negedge clk);
		core.access(1'b0, 1'b1, 16'h0003, 16'h0006);
		@(negedge clk);
		core.access(1'b0, 1'b1, 16'h0002, 16'h0008);
		core.irqEnable = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 600; i++) begin
			op = $urandom_range(0, 9);
			a = 16'($urandom_range(1, 4));
			d = 16'($urandom_range(0, 9));
			case (op)
				0, 1, 2: core.access(1'b1, 1'b0, a, d);
				3, 4: core.access(1'b0, 1'b1, 16'h0003, d);
				5, 6: core.access(1'b0, 1'b1, 16'h0002, d);
				7: core.access(1'b1, 1'b1, a, d);
				8: core.access(1'b0, 1'b1, a, d);
				default: begin
					resetn = 0;
					repeat (2) @(negedge clk);
					resetn = 1;
				end
			endcase
			repeat ($urandom_range(1, 6)) @(negedge clk);
		end
		repeat (3) @(negedge clk);
		// Let the partner finish counting at this falling edge before comparing.
		#1;
		check("irqCount", core.irqCount[15:0], mIrqs[15:0]);
		final_report();
	end
endmodule // periodic_down_timer_tb_top
